// ---- src/fpes_pkg.sv ----
// Constants and types for the flash program/erase sequencer
package fpes_pkg;
  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int MEM_AW = 7;
  localparam int MEM_SIZE = 128;
  localparam int SECT_W = 3;
  localparam int NSECT = 8;
  localparam int BYTE_W = MEM_AW - SECT_W;
  localparam int CNT_W = 12;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam int STATE_W = 15;
  // ---------------------------------------------------------------
  // Command decode constants
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] UNL_ADDR1 = 12'h555;
  localparam logic [ADDR_W-1:0] UNL_ADDR2 = 12'haaa;
  localparam logic [DATA_W-1:0] UNL_DATA1 = 8'haa;
  localparam logic [DATA_W-1:0] UNL_DATA2 = 8'h55;
  localparam logic [DATA_W-1:0] CMD_PROG = 8'ha0;
  localparam logic [DATA_W-1:0] CMD_BYPASS = 8'h20;
  localparam logic [DATA_W-1:0] CMD_ERASE = 8'h80;
  localparam logic [DATA_W-1:0] CMD_BULK = 8'h10;
  localparam logic [DATA_W-1:0] CMD_SECTOR = 8'h30;
  localparam logic [DATA_W-1:0] CMD_SUSPEND = 8'hb0;
  localparam logic [DATA_W-1:0] CMD_RESUME = 8'h30;
  localparam logic [DATA_W-1:0] CMD_BYP_EXIT1 = 8'h90;
  localparam logic [DATA_W-1:0] CMD_BYP_EXIT2 = 8'h00;
  localparam logic [DATA_W-1:0] CMD_RESET = 8'hf0;
  localparam logic [DATA_W-1:0] ERASED = 8'hff;
  localparam logic [DATA_W-1:0] ZEROED = 8'h00;
  localparam logic [NSECT-1:0] SECT_ONE = 8'h01;
  // ---------------------------------------------------------------
  // Status byte bit positions
  // ---------------------------------------------------------------
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int ERR_BIT = 5;
  localparam int TIMER_BIT = 3;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int WIN_NS = 100000;
  localparam int WIN_CYC = (WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] WIN_LAST = CNT_W'(WIN_CYC - 1);
  localparam logic [CNT_W-1:0] PROG_LAST = 12'h00f;
  // ---------------------------------------------------------------
  // APB register map
  // ---------------------------------------------------------------
  localparam logic [APB_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] REG_STATUS = 8'h04;
  localparam logic [APB_AW-1:0] REG_SECTORS = 8'h08;
  localparam int CTRL_FAIL_BIT = 0;
  localparam int CTRL_PROT_LSB = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_ERR = 1;
  localparam int ST_TIMER = 2;
  localparam int ST_BYP = 3;
  localparam int ST_SUSP = 4;
  localparam int ST_BULK = 5;
  localparam int ST_STATE_LSB = 16;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic sel;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fpes_mcu_req_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata;
  } fpes_apb_req_t;
  typedef enum logic [STATE_W-1:0] {
    S_READ = 15'h0001, S_U1 = 15'h0002, S_U2 = 15'h0004,
    S_PADDR = 15'h0008, S_E3 = 15'h0010, S_E4 = 15'h0020,
    S_E5 = 15'h0040, S_WIN = 15'h0080, S_ERASE = 15'h0100,
    S_SUSP = 15'h0200, S_PROG = 15'h0400, S_BYP = 15'h0800,
    S_BYPA0 = 15'h1000, S_BYP90 = 15'h2000, S_FAIL = 15'h4000
  } fpes_state_t;
endpackage

// ---- src/fpes_top.sv ----
// Flash program/erase command sequencer with status reads and APB registers
module fpes_top (
  input wire logic CLK,
  input wire logic NRST,
  input wire fpes_pkg::fpes_mcu_req_t MCU_REQ,
  output logic [fpes_pkg::DATA_W-1:0] MCU_RDATA,
  output logic RDY_BUSY,
  input wire fpes_pkg::fpes_apb_req_t APB_REQ,
  output logic PREADY,
  output logic [fpes_pkg::APB_DW-1:0] PRDATA,
  output logic PSLVERR
);
  import fpes_pkg::*;

  fpes_state_t state_r, state_nxt;
  logic [DATA_W-1:0] mem_r [0:MEM_SIZE-1];
  logic [MEM_AW-1:0] tgt_r, idx_r;
  logic [DATA_W-1:0] tgt_data_r, rdata_r, stat_w;
  logic [NSECT-1:0] mask_r, prot_r;
  logic [CNT_W-1:0] cnt_r;
  logic [APB_DW-1:0] prdata_r, apb_rd_w;
  logic bad_r, byp_r, fail_r, op_prog_r, bulk_r, phase_r;
  logic err_r, timer_r, toggle_r, rdy_r, fail_inj_r;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire mcu_wr = MCU_REQ.wr;
  wire mcu_rd = MCU_REQ.rd;
  wire sel_wr = mcu_wr && MCU_REQ.sel;
  wire [DATA_W-1:0] wd = MCU_REQ.wdata;
  wire [MEM_AW-1:0] a_idx = MCU_REQ.addr[MEM_AW-1:0];
  wire [SECT_W-1:0] a_sect = MCU_REQ.addr[MEM_AW-1:BYTE_W];
  wire a_prot = prot_r[a_sect];
  wire [DATA_W-1:0] a_old = mem_r[a_idx];
  wire a_bad = |(~a_old & wd);
  wire [NSECT-1:0] a_oh = SECT_ONE << a_sect;
  wire is_unl1 = mcu_wr && wd == UNL_DATA1 && MCU_REQ.addr == UNL_ADDR1;
  wire is_unl2 = mcu_wr && wd == UNL_DATA2 && MCU_REQ.addr == UNL_ADDR2;
  wire reset_cmd = mcu_wr && wd == CMD_RESET;
  wire susp_cmd = sel_wr && wd == CMD_SUSPEND;
  wire resume_cmd = sel_wr && wd == CMD_RESUME;
  wire start_prog = (state_r == S_PADDR || state_r == S_BYPA0) && sel_wr &&
                    !a_prot;
  wire start_bulk = state_r == S_E5 && mcu_wr && wd == CMD_BULK &&
                    MCU_REQ.addr == UNL_ADDR1;
  wire start_sect = state_r == S_E5 && sel_wr && wd == CMD_SECTOR &&
                    !a_prot;
  wire add_sect = state_r == S_WIN && mcu_wr && wd == CMD_SECTOR;
  wire win_susp = state_r == S_WIN && susp_cmd;
  wire win_end = cnt_r == WIN_LAST;
  wire win_to_erase = state_r == S_WIN && state_nxt == S_ERASE;
  wire walk_last = idx_r == {MEM_AW{1'b1}};
  wire walk_hit = mask_r[idx_r[MEM_AW-1:BYTE_W]];
  wire erase_wr = state_r == S_ERASE && walk_hit;
  wire erase_done = state_r == S_ERASE && walk_last && phase_r;
  wire prog_end = state_r == S_PROG && cnt_r == '0;
  wire prog_commit = prog_end && !fail_r && !bad_r;
  wire busy_nxt = state_nxt == S_PROG || state_nxt == S_WIN ||
                  state_nxt == S_ERASE || state_nxt == S_FAIL;
  wire prog_hit = mcu_rd && a_idx == tgt_r &&
                  (state_r == S_PROG || (state_r == S_FAIL && op_prog_r));
  wire erase_hit = mcu_rd && mask_r[a_sect] && (state_r == S_WIN ||
                   state_r == S_ERASE || (state_r == S_FAIL && !op_prog_r));
  wire stat_rd = prog_hit || erase_hit;

  // ---------------------------------------------------------------
  // Command sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_READ: begin
        if (is_unl1) state_nxt = S_U1;
      end
      S_U1: begin
        if (mcu_wr) state_nxt = is_unl2 ? S_U2 : S_READ;
      end
      S_U2: begin
        if (mcu_wr) begin
          if (wd == CMD_PROG) state_nxt = S_PADDR;
          else if (wd == CMD_BYPASS) state_nxt = S_BYP;
          else if (wd == CMD_ERASE) state_nxt = S_E3;
          else state_nxt = S_READ;
        end
      end
      S_PADDR: begin
        if (mcu_wr) state_nxt = start_prog ? S_PROG : S_READ;
      end
      S_E3: begin
        if (mcu_wr) state_nxt = is_unl1 ? S_E4 : S_READ;
      end
      S_E4: begin
        if (mcu_wr) state_nxt = is_unl2 ? S_E5 : S_READ;
      end
      S_E5: begin
        if (start_bulk) state_nxt = S_ERASE;
        else if (start_sect) state_nxt = S_WIN;
        else if (mcu_wr) state_nxt = S_READ;
      end
      S_WIN: begin
        if (win_susp) state_nxt = S_SUSP;
        else if (add_sect) state_nxt = S_WIN;
        else if (mcu_wr) state_nxt = S_READ;
        else if (win_end) state_nxt = S_ERASE;
      end
      S_ERASE: begin
        if (erase_done) state_nxt = fail_r ? S_FAIL : S_READ;
        else if (!bulk_r && susp_cmd) state_nxt = S_SUSP;
        else if (!bulk_r && reset_cmd) state_nxt = S_READ;
      end
      S_SUSP: begin
        if (resume_cmd) state_nxt = S_ERASE;
        else if (reset_cmd) state_nxt = S_READ;
      end
      S_PROG: begin
        if (prog_end) begin
          if (fail_r || bad_r) state_nxt = S_FAIL;
          else state_nxt = byp_r ? S_BYP : S_READ;
        end
      end
      S_BYP: begin
        if (mcu_wr && wd == CMD_PROG) state_nxt = S_BYPA0;
        else if (mcu_wr && wd == CMD_BYP_EXIT1) state_nxt = S_BYP90;
      end
      S_BYPA0: begin
        if (mcu_wr) state_nxt = start_prog ? S_PROG : S_BYP;
      end
      S_BYP90: begin
        if (mcu_wr) begin
          state_nxt = (wd == CMD_BYP_EXIT2) ? S_READ : S_BYP;
        end
      end
      S_FAIL: begin
        if (reset_cmd) state_nxt = S_READ;
      end
      default: state_nxt = S_READ;
    endcase
  end
  always_ff @(posedge CLK) begin
    if (!NRST) state_r <= S_READ;
    else state_r <= state_nxt;
  end
  // Operation context captured at start
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      tgt_r <= '0;
      tgt_data_r <= '0;
      bad_r <= 1'b0;
      byp_r <= 1'b0;
      fail_r <= 1'b0;
      op_prog_r <= 1'b0;
      bulk_r <= 1'b0;
    end else if (start_prog) begin
      tgt_r <= a_idx;
      tgt_data_r <= wd;
      bad_r <= a_bad;
      byp_r <= state_r == S_BYPA0;
      fail_r <= fail_inj_r;
      op_prog_r <= 1'b1;
    end else if (start_bulk || start_sect) begin
      fail_r <= fail_inj_r;
      op_prog_r <= 1'b0;
      bulk_r <= start_bulk;
    end
  end
  // Window and program timer
  always_ff @(posedge CLK) begin
    if (!NRST) cnt_r <= '0;
    else if (start_prog) cnt_r <= PROG_LAST;
    else if (start_sect || add_sect) cnt_r <= '0;
    else if (state_r == S_PROG) cnt_r <= cnt_r - 1'b1;
    else if (state_r == S_WIN) cnt_r <= cnt_r + 1'b1;
  end
  // Sectors taking part in the erase
  always_ff @(posedge CLK) begin
    if (!NRST) mask_r <= '0;
    else if (start_bulk) mask_r <= ~prot_r;
    else if (start_sect) mask_r <= a_oh;
    else if (add_sect && !a_prot) mask_r <= mask_r | a_oh;
    else if (state_nxt == S_READ && (state_r == S_WIN ||
             state_r == S_ERASE || state_r == S_SUSP)) mask_r <= '0;
  end
  // Erase walk: zero pass first, then ones pass
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      idx_r <= '0;
      phase_r <= 1'b0;
    end else if (start_bulk || win_to_erase || win_susp) begin
      idx_r <= '0;
      phase_r <= 1'b0;
    end else if (state_r == S_ERASE) begin
      idx_r <= idx_r + 1'b1;
      if (walk_last) phase_r <= !phase_r;
    end
  end
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      for (int i = 0; i < MEM_SIZE; i++) begin
        mem_r[i] <= ERASED;
      end
    end else if (prog_commit) begin
      mem_r[tgt_r] <= tgt_data_r;
    end else if (erase_wr) begin
      mem_r[idx_r] <= phase_r ? ERASED : ZEROED;
    end
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!NRST) timer_r <= 1'b1;
    else if (start_sect || add_sect) timer_r <= 1'b0;
    else if (state_r == S_WIN && state_nxt != S_WIN) timer_r <= 1'b1;
  end
  always_ff @(posedge CLK) begin
    if (!NRST) err_r <= 1'b0;
    else if (state_nxt == S_FAIL && state_r != S_FAIL) err_r <= 1'b1;
    else if (state_r == S_FAIL && reset_cmd) err_r <= 1'b0;
  end
  always_ff @(posedge CLK) begin
    if (!NRST) toggle_r <= 1'b0;
    else if (stat_rd) toggle_r <= !toggle_r;
  end
  always_comb begin
    stat_w = '0;
    stat_w[POLL_BIT] = prog_hit ? !tgt_data_r[POLL_BIT] : 1'b0;
    stat_w[TOGGLE_BIT] = toggle_r;
    stat_w[ERR_BIT] = err_r;
    stat_w[TIMER_BIT] = timer_r;
  end
  always_ff @(posedge CLK) begin
    if (!NRST) rdata_r <= '0;
    else if (mcu_rd) rdata_r <= stat_rd ? stat_w : a_old;
  end
  always_ff @(posedge CLK) begin
    if (!NRST) rdy_r <= 1'b1;
    else rdy_r <= !busy_nxt;
  end
  assign MCU_RDATA = rdata_r;
  assign RDY_BUSY = rdy_r;

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  wire apb_setup = APB_REQ.psel && !APB_REQ.penable;
  wire apb_acc = APB_REQ.psel && APB_REQ.penable;
  wire hit_ctrl = APB_REQ.paddr == REG_CTRL;
  wire hit_stat = APB_REQ.paddr == REG_STATUS;
  wire hit_sect = APB_REQ.paddr == REG_SECTORS;
  wire mapped = hit_ctrl || hit_stat || hit_sect;
  wire ctrl_wr = apb_acc && APB_REQ.pwrite && hit_ctrl;
  always_comb begin
    apb_rd_w = '0;
    if (hit_ctrl) begin
      apb_rd_w[CTRL_FAIL_BIT] = fail_inj_r;
      apb_rd_w[CTRL_PROT_LSB +: NSECT] = prot_r;
    end else if (hit_stat) begin
      apb_rd_w[ST_BUSY] = !rdy_r;
      apb_rd_w[ST_ERR] = err_r;
      apb_rd_w[ST_TIMER] = timer_r;
      apb_rd_w[ST_BYP] = state_r == S_BYP || state_r == S_BYPA0 ||
                         state_r == S_BYP90 || (state_r == S_PROG && byp_r);
      apb_rd_w[ST_SUSP] = state_r == S_SUSP;
      apb_rd_w[ST_BULK] = bulk_r;
      apb_rd_w[ST_STATE_LSB +: STATE_W] = state_r;
    end else if (hit_sect) begin
      apb_rd_w[NSECT-1:0] = mask_r;
    end
  end
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      fail_inj_r <= 1'b0;
      prot_r <= '0;
    end else if (ctrl_wr) begin
      fail_inj_r <= APB_REQ.pwdata[CTRL_FAIL_BIT];
      prot_r <= APB_REQ.pwdata[CTRL_PROT_LSB +: NSECT];
    end
  end
  always_ff @(posedge CLK) begin
    if (!NRST) prdata_r <= '0;
    else if (apb_setup && !APB_REQ.pwrite) prdata_r <= apb_rd_w;
  end
  assign PREADY = 1'b1;
  assign PRDATA = prdata_r;
  assign PSLVERR = apb_acc && !mapped;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  win_flag_low_a: assert property (state_r == S_WIN |-> !timer_r &&
    cnt_r <= WIN_LAST)
    else $error("timer flag or count wrong inside window");
  win_expiry_a: assert property ((state_r == S_WIN && !mcu_wr &&
    win_end) |=> state_r == S_ERASE && timer_r)
    else $error("window expiry did not start erase");
  erase_ones_a: assert property ((erase_wr && phase_r) |=>
    mem_r[$past(idx_r)] == ERASED)
    else $error("erased byte not all ones");
  erase_zero_a: assert property ((erase_wr && !phase_r) |=>
    mem_r[$past(idx_r)] == ZEROED)
    else $error("erase did not clear byte first");
  prog_store_a: assert property (prog_commit |=>
    mem_r[$past(tgt_r)] == $past(tgt_data_r))
    else $error("programmed byte not stored");
  busy_pin_a: assert property ((state_r == S_PROG ||
    state_r == S_ERASE) |-> !RDY_BUSY)
    else $error("ready pin high while busy");
  poll_inv_a: assert property (prog_hit && state_r == S_PROG |=>
    MCU_RDATA[POLL_BIT] != tgt_data_r[POLL_BIT])
    else $error("poll bit not inverted during program");
  bad_bit_a: assert property ((prog_end && bad_r) |=>
    state_r == S_FAIL && err_r)
    else $error("zero-to-one program did not flag error");
  erase_poll_a: assert property ((erase_hit && state_r == S_ERASE) |=>
    !MCU_RDATA[POLL_BIT] && !MCU_RDATA[ERR_BIT])
    else $error("erase status read wrong");
  toggle_flip_a: assert property (stat_rd |=>
    MCU_RDATA[TOGGLE_BIT] == !toggle_r)
    else $error("toggle bit did not flip");
  byp_only_a: assert property ((state_r == S_BYP && mcu_wr &&
    wd != CMD_PROG && wd != CMD_BYP_EXIT1) |=> state_r == S_BYP)
    else $error("bypass mode left on foreign command");
  seq_abort_a: assert property ((state_r == S_E4 && mcu_wr &&
    !is_unl2) |=> state_r == S_READ)
    else $error("bad erase sequence not aborted");
  bulk_deaf_a: assert property ((state_r == S_ERASE && bulk_r &&
    !erase_done) |=> state_r == S_ERASE)
    else $error("bulk erase interrupted");
  sect_add_a: assert property ((add_sect && !a_prot) |=>
    mask_r[$past(a_sect)] && cnt_r == '0)
    else $error("extra sector not added or window not restarted");
  win_abort_a: assert property ((state_r == S_WIN && mcu_wr &&
    wd != CMD_SECTOR && wd != CMD_SUSPEND) |=> state_r == S_READ)
    else $error("window not aborted by foreign command");
endmodule // fpes_top

// ---- verification/fpes_mcu.sv ----
// Microcontroller bus model for the sequencer's host port
module fpes_mcu (
  input wire logic clk,
  input wire logic [fpes_pkg::DATA_W-1:0] rdata,
  output fpes_pkg::fpes_mcu_req_t req
);
  timeunit 1ns;
  timeprecision 1ns;
  import fpes_pkg::*;
  logic [DATA_W-1:0] q;
  initial req = '{1'b0, 1'b0, 1'b0, 12'h000, 8'hff};
  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  // Released address and data show the inverse; strobes and select drop low
  task automatic cyc(input logic w, input logic s,
    input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    req <= '{w, !w, s, a, d};
    @(posedge clk);
    req <= '{1'b0, 1'b0, 1'b0, ~a, ~d};
    @(posedge clk);
    q = rdata;
  endtask
  task automatic unl();
    cyc(1'b1, 1'b0, UNL_ADDR1, UNL_DATA1);
    cyc(1'b1, 1'b0, UNL_ADDR2, UNL_DATA2);
  endtask
endmodule // fpes_mcu

// ---- verification/tb_top.sv ----
// Self-checking bench for the flash program/erase sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fpes_pkg::*;
  typedef struct {logic [7:0] e; logic [7:0] m; bit t;} fpes_note_t;
  logic clk, nrst, pready, pslverr, rdy_busy, e, prev6;
  fpes_mcu_req_t mcu_req;
  fpes_apb_req_t apb_req;
  logic [DATA_W-1:0] mcu_rdata, d, s;
  logic [APB_DW-1:0] prdata, r;
  logic [ADDR_W-1:0] sa, sb;
  int miscompares, comparisons;
  fpes_note_t notes[$];
  fpes_top fpes_top_i (.CLK(clk), .NRST(nrst), .MCU_REQ(mcu_req),
    .MCU_RDATA(mcu_rdata), .RDY_BUSY(rdy_busy), .APB_REQ(apb_req),
    .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr));
  fpes_mcu fpes_mcu_i (.clk(clk), .rdata(mcu_rdata), .req(mcu_req));
  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic cmp(input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      miscompares++;
      $display("Error t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask
  task automatic end_sim();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    fpes_note_t n;
    if (mcu_req.rd) begin
      #1;
      n = notes.pop_front();
      if (n.m != 8'h00) cmp(n.e & n.m, mcu_rdata & n.m);
      if (n.t) cmp(!prev6, mcu_rdata[6]);
      prev6 = mcu_rdata[6];
    end
  end
  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] wd);
    int k;
    apb_req <= '{1'b1, 1'b0, w, a, wd};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 50) begin
      miscompares++;
      end_sim();
    end
    r = prdata;
    e = pslverr;
    apb_req <= '{1'b0, 1'b0, 1'b0, ~a, ~wd};
    @(posedge clk);
  endtask
  task automatic wr(input [11:0] a, input [7:0] x, input logic sl = 0);
    fpes_mcu_i.cyc(1'b1, sl, a, x);
  endtask
  task automatic rd(input [11:0] a, input [7:0] x, input [7:0] m,
    input bit t);
    notes.push_back('{x, m, t});
    fpes_mcu_i.cyc(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic wait_rdy(input int lim);
    int k;
    repeat (2) @(posedge clk);
    for (k = 0; k < lim && rdy_busy !== 1'b1; k++) @(posedge clk);
    if (k == lim) begin
      miscompares++;
      end_sim();
    end
  endtask
  task automatic poll(input [11:0] a, input [7:0] x);
    int k;
    for (k = 0; k < 100; k++) begin
      rd(a, 8'h00, 8'h00, 0);
      if (fpes_mcu_i.q[7] === x[7] && fpes_mcu_i.q[5] === 1'b0) break;
      if (fpes_mcu_i.q[5] === 1'b1) begin
        rd(a, 8'h00, 8'h00, 0);
        break;
      end
    end
    if (k == 100) begin
      miscompares++;
      end_sim();
    end
  endtask
  task automatic prog(input [11:0] a, input [7:0] x);
    fpes_mcu_i.unl();
    wr(UNL_ADDR1, CMD_PROG);
    wr(a, x, 1'b1);
  endtask
  task automatic ers(input [7:0] c, input [11:0] a, input logic sl);
    fpes_mcu_i.unl();
    wr(UNL_ADDR1, CMD_ERASE);
    fpes_mcu_i.unl();
    wr(a, c, sl);
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    nrst = 1'b0;
    apb_req = '0;
    miscompares = 0;
    comparisons = 0;
    prev6 = 1'b0;
    void'($urandom(59));
    d = 8'($urandom) & 8'h7f;
    s = 8'(1 + $urandom % 2);
    sa = {5'h00, s[2:0], 4'h2};
    sb = {5'h00, s[2:0] + 3'h1, 4'h2};
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    apb(0, REG_CTRL, 0);
    cmp(0, r);
    apb(0, REG_STATUS, 0);
    cmp(32'h0001_0004, r);
    apb(0, 8'h0c, 0);
    cmp(1, e);
    prog(12'h012, d);
    #1 cmp(0, rdy_busy);
    rd(12'h012, {~d[7], 7'h00}, 8'ha0, 0);
    rd(12'h012, 8'h00, 8'h00, 1);
    rd(12'h012, 8'h00, 8'h00, 1);
    poll(12'h012, d);
    wait_rdy(100);
    rd(12'h012, d, 8'hff, 0);
    prog(12'h012, ~d);
    repeat (20) @(posedge clk);
    rd(12'h012, 8'h20, 8'h20, 0);
    wr(12'h000, CMD_RESET);
    wait_rdy(20);
    // Injected program failure
    apb(1, REG_CTRL, 32'h0000_0001);
    prog(12'h030, 8'h5a);
    repeat (20) @(posedge clk);
    rd(12'h030, 8'ha0, 8'ha0, 0);
    wr(12'h000, CMD_RESET);
    wait_rdy(20);
    apb(1, REG_CTRL, 32'h0000_8000);
    apb(0, REG_CTRL, 0);
    cmp(32'h0000_8000, r);
    prog(12'h070, 8'h00);
    #1 cmp(1, rdy_busy);
    rd(12'h070, ERASED, 8'hff, 0);
    apb(1, REG_CTRL, 0);
    fpes_mcu_i.unl();
    wr(UNL_ADDR1, CMD_BYPASS);
    for (int k = 0; k < 2; k++) begin
      wr(12'h000, CMD_PROG);
      wr(12'h020 + 12'(k), d + 8'(k), 1'b1);
      wait_rdy(100);
    end
    wr(12'h000, CMD_ERASE);
    apb(0, REG_STATUS, 0);
    cmp(1, r[ST_BYP]);
    wr(12'h5a5, CMD_BYP_EXIT1);
    wr(12'h333, CMD_BYP_EXIT2);
    apb(0, REG_STATUS, 0);
    cmp(0, r[ST_BYP]);
    rd(12'h021, d + 8'h01, 8'hff, 0);
    ers(CMD_SECTOR, sa, 1'b1);
    rd(sa, 8'h00, 8'h88, 0);
    wr(sb, CMD_SECTOR, 1'b1);
    apb(0, REG_SECTORS, 0);
    cmp(32'(8'h03 << s[2:0]), r);
    repeat (2400) @(posedge clk);
    rd(sa, 8'h00, 8'h08, 0);
    repeat (150) @(posedge clk);
    rd(sb, 8'h08, 8'h88, 0);
    rd(sb, 8'h00, 8'h00, 1);
    wr(12'h000, 8'h55);
    #1 cmp(0, rdy_busy);
    wait_rdy(1000);
    rd(sa, ERASED, 8'hff, 0);
    rd(sb, ERASED, 8'hff, 0);
    ers(CMD_SECTOR, sa, 1'b1);
    wr(12'h000, 8'h55);
    wait_rdy(3);
    ers(CMD_SECTOR, sa, 1'b1);
    wr(12'h000, CMD_SUSPEND, 1'b1);
    apb(0, REG_STATUS, 0);
    cmp(1, r[ST_SUSP]);
    wr(12'h000, CMD_RESUME, 1'b1);
    wait_rdy(1000);
    fpes_mcu_i.unl();
    wr(UNL_ADDR1, CMD_ERASE);
    fpes_mcu_i.unl();
    wr(UNL_ADDR1, 8'h11);
    #1 cmp(1, rdy_busy);
    @(posedge clk);
    apb(0, REG_STATUS, 0);
    cmp(32'(S_READ), r[ST_STATE_LSB +: STATE_W]);
    ers(CMD_BULK, UNL_ADDR1, 1'b0);
    rd(12'h000, 8'h00, 8'h80, 0);
    wr(12'h000, CMD_RESET);
    #1 cmp(0, rdy_busy);
    @(posedge clk);
    apb(0, REG_STATUS, 0);
    cmp(1, r[ST_BULK]);
    wait_rdy(1000);
    rd(12'h020, ERASED, 8'hff, 0);
    // Injected sector erase failure
    apb(1, REG_CTRL, 32'h0000_0001);
    ers(CMD_SECTOR, sa, 1'b1);
    repeat (2800) @(posedge clk);
    rd(sa, 8'h20, 8'ha0, 0);
    wr(12'h000, CMD_RESET);
    wait_rdy(20);
    end_sim();
  end
endmodule // tb_top
